// ==== core/mpa_regs.svh ====
// constants for the mirror pixel array
`ifndef MPA_REGS_SVH
`define MPA_REGS_SVH
`define MPA_ROWS        1080
`define MPA_COLS        16
`define MPA_BORDER      14
`define MPA_GROUPS      8
`define MPA_LANES       16
`define MPA_FIFO_DEPTH  8
`define MPA_PULSE_NS    8
`define MPA_CLK_NS      4
`endif

// ==== core/mpa_pkg.sv ====
// types shared by the mirror pixel array
package mpa_pkg;
  typedef struct packed {
    logic [15:0] data;
    logic        row_start;
  } mpa_word_s;
  typedef enum logic [2:0] {
    MPA_IDLE  = 3'b001,
    MPA_PULSE = 3'b010,
    MPA_DONE  = 3'b100
  } mpa_state_e;
endpackage

// ==== core/mpa_fifo.sv ====
// small valid/ready fifo between link capture and cell writer
`timescale 1ns/1ps
module mpa_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_reg];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== core/mpa_array.sv ====
// mirror pixel array: ddr link capture, cell grid, group reset, mirror state
`timescale 1ns/1ps
`include "mpa_regs.svh"
module mpa_array
  import mpa_pkg::*;
#(
  parameter int COLS   = `MPA_COLS,
  parameter int ROWS   = `MPA_ROWS,
  parameter int BORDER = `MPA_BORDER,
  parameter int GROUPS = `MPA_GROUPS,
  parameter int LANES  = `MPA_LANES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              link_clk,
  input  wire logic [LANES-1:0]  link_data,
  input  wire logic              link_row_start,
  input  wire logic [GROUPS-1:0] reset_request,
  output logic                   link_ready,
  output logic [GROUPS-1:0]      mirror_reset_group_signal,
  output logic [COLS-1:0]        cell_true_row,
  output logic [COLS-1:0]        cell_complement_output,
  output logic [COLS-1:0]        mirror_tilt_row,
  input  wire logic [$clog2(ROWS)-1:0] view_row,
  output logic                   reset_busy
);
  localparam int RW    = $clog2(ROWS);
  localparam int CW    = $clog2(COLS+1);
  localparam int RPG   = (ROWS + GROUPS - 1) / GROUPS;
  localparam int PULSE = (`MPA_PULSE_NS + `MPA_CLK_NS - 1) / `MPA_CLK_NS;

  // group of a row, used by the mirror latch at pulse end
  function automatic int row_group(input logic [RW-1:0] r);
    return int'(r) / RPG;
  endfunction

  // border band mask: cells in band forced to zero when latched into mirror state
  function automatic logic in_border(input int r, input int c);
    return (r < BORDER) || (r >= ROWS - BORDER) || (c < BORDER) || (c >= COLS - BORDER);
  endfunction

  // three-stage sampling of link pins; second and third link_clk stages agree before use
  logic [2:0]       lclk_sync;
  logic [LANES:0]   ld_s1;
  logic [LANES:0]   ld_s2;
  logic [LANES:0]   ld_s3;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lclk_sync <= '0;
      ld_s1     <= '0;
      ld_s2     <= '0;
      ld_s3     <= '0;
    end else begin
      lclk_sync <= {lclk_sync[1:0], link_clk};
      ld_s1     <= {link_row_start, link_data};
      ld_s2     <= ld_s1;
      ld_s3     <= ld_s2;
    end
  end
  logic lclk_edge;
  logic lclk_last_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lclk_last_reg <= 1'b0;
    end else if (lclk_sync[1] == lclk_sync[2]) begin
      lclk_last_reg <= lclk_sync[2];
    end
  end
  // both edges carry a word; slow link keeps data stable around each edge
  assign lclk_edge = (lclk_sync[1] == lclk_sync[2]) && (lclk_sync[2] != lclk_last_reg);

  mpa_word_s in_word;
  mpa_word_s out_word;
  logic      fifo_in_ready;
  logic      fifo_out_valid;
  logic      wr_ready;
  assign in_word.data      = ld_s3[LANES-1:0];
  assign in_word.row_start = ld_s3[LANES];
  assign link_ready        = fifo_in_ready;

  mpa_fifo #(.WIDTH($bits(mpa_word_s)), .DEPTH(`MPA_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (in_word),
    .in_valid  (lclk_edge),
    .in_ready  (fifo_in_ready),
    .out_data  (out_word),
    .out_valid (fifo_out_valid),
    .out_ready (wr_ready)
  );

  // cell storage and displayed mirror state, one bit per mirror
  logic [COLS-1:0] cells  [ROWS];
  logic [COLS-1:0] mirror [ROWS];
  logic [RW-1:0]   wrow_reg;
  logic [CW-1:0]   wcol_reg;
  logic [COLS-1:0] wbuf_reg;
  logic            wcommit;

  // writer stalls while reset_busy is high, through both the pulse and the latch
  assign wr_ready = !reset_busy;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrow_reg <= '0;
      wcol_reg <= '0;
      wbuf_reg <= '0;
      wcommit  <= 1'b0;
    end else begin
      wcommit <= 1'b0;
      if (fifo_out_valid && wr_ready) begin
        for (int i = 0; i < LANES; i++) begin
          if (int'(wcol_reg) + i < COLS) begin
            wbuf_reg[int'(wcol_reg) + i] <= out_word.data[i];
          end
        end
        if (out_word.row_start) begin
          wrow_reg <= (wcommit || wcol_reg != '0) ? wrow_reg : '0;
        end
        if (int'(wcol_reg) + LANES >= COLS) begin
          wcol_reg <= '0;
          wcommit  <= 1'b1;
        end else begin
          wcol_reg <= wcol_reg + CW'(LANES);
        end
      end
      if (wcommit) begin
        wrow_reg <= (int'(wrow_reg) == ROWS-1) ? '0 : wrow_reg + RW'(1);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (wcommit) begin
      cells[wrow_reg] <= wbuf_reg;
    end
  end

  // internal pulse generator; controller only requests groups
  mpa_state_e      st_reg;
  logic [GROUPS-1:0] sel_reg;
  logic [3:0]      pcnt_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg   <= MPA_IDLE;
      sel_reg  <= '0;
      pcnt_reg <= '0;
    end else begin
      case (st_reg)
        MPA_IDLE: begin
          if (reset_request != '0 && !wcommit) begin
            sel_reg  <= reset_request;
            pcnt_reg <= 4'(PULSE);
            st_reg   <= MPA_PULSE;
          end
        end
        MPA_PULSE: begin
          pcnt_reg <= pcnt_reg - 4'h1;
          if (pcnt_reg == 4'h1) begin
            st_reg <= MPA_DONE;
          end
        end
        MPA_DONE: begin
          sel_reg <= '0;
          st_reg  <= MPA_IDLE;
        end
        default: begin
          st_reg <= MPA_IDLE;
        end
      endcase
    end
  end
  assign reset_busy = (st_reg != MPA_IDLE);
  assign mirror_reset_group_signal = (st_reg == MPA_PULSE) ? sel_reg : '0;

  // latch at pulse end; only selected groups take new state
  always_ff @(posedge clk) begin
    if (st_reg == MPA_DONE) begin
      for (int r = 0; r < ROWS; r++) begin
        if (sel_reg[row_group(RW'(r))]) begin
          for (int c = 0; c < COLS; c++) begin
            // one gives positive tilt, zero negative; band always off
            mirror[r][c] <= cells[r][c] && !in_border(r, c);
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cell_true_row          <= '0;
      cell_complement_output <= '1;
      mirror_tilt_row        <= '0;
    end else begin
      cell_true_row          <= cells[view_row];
      cell_complement_output <= ~cells[view_row];
      mirror_tilt_row        <= mirror[view_row];
    end
  end
endmodule

// ==== bench/mpa_checker.sv ====
// port assertions for the mirror pixel array
`timescale 1ns/1ps
module mpa_checker #(
  parameter int COLS   = 16,
  parameter int ROWS   = 1080,
  parameter int GROUPS = 8
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic [GROUPS-1:0]       reset_request,
  input wire logic                    link_ready,
  input wire logic [GROUPS-1:0]       mirror_reset_group_signal,
  input wire logic [COLS-1:0]         cell_true_row,
  input wire logic [COLS-1:0]         cell_complement_output,
  input wire logic [COLS-1:0]         mirror_tilt_row,
  input wire logic [$clog2(ROWS)-1:0] view_row,
  input wire logic                    reset_busy
);
  logic [2:0] quiet_reg;
  logic       armed_reg;
  wire        pulse = |mirror_reset_group_signal;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // memories are unknown until the first pulse, so judge only after it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_reg <= 3'h0;
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_reg | pulse;
      if (reset_busy || !$stable(view_row)) quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
    end
  end
  sequence s_pulse2;
    pulse [*2] ##1 !pulse;
  endsequence
  sequence s_busy3;
    reset_busy [*3] ##1 !reset_busy;
  endsequence
  a_pulse_width: assert property ($rose(pulse) |-> s_pulse2)
    else $error("pulse not two cycles");
  a_busy_length: assert property ($rose(reset_busy) |-> s_busy3)
    else $error("busy not three cycles");
  a_pulse_groups: assert property ($rose(pulse) |->
    mirror_reset_group_signal == $past(reset_request) ##1 $stable(mirror_reset_group_signal))
    else $error("pulse on wrong groups");
  a_pulse_in_busy: assert property (pulse |-> reset_busy)
    else $error("pulse outside busy");
  a_request_starts: assert property ((!reset_busy && |reset_request) |-> ##[1:2] pulse)
    else $error("request gave no pulse");
  a_comp_inverse: assert property (armed_reg |-> cell_complement_output == ~cell_true_row)
    else $error("complement not inverse");
  a_tilt_hold: assert property ((armed_reg && quiet_reg >= 3'h4) |-> $stable(mirror_tilt_row))
    else $error("tilt moved without pulse");
  a_reset_values: assert property ($fell(rst) |->
    !pulse && !reset_busy && link_ready && mirror_tilt_row == '0)
    else $error("bad values after reset");
endmodule

// ==== bench/mpa_link_model.sv ====
// controller model: one word per link clock edge, clock still between frames
`timescale 1ns/1ps
module mpa_link_model (
  output logic        link_clk,
  output logic [15:0] link_data,
  output logic        link_row_start
);
  initial begin
    link_clk = 1'b0;
    link_data = 16'h0000;
    link_row_start = 1'b0;
  end
  // data leads each edge by half a bit so the sampled copy is settled
  task automatic send_rows(input int rows, input int words, input logic [15:0] value);
    for (int k = 0; k < rows * words; k++) begin
      link_data = value;
      // only the first word of a frame: the writer rewinds to row 0 on it
      link_row_start = (k == 0);
      #8 link_clk = ~link_clk;
      #8;
    end
    link_row_start = 1'b0;
    link_data = ~value;
  endtask
endmodule

// ==== bench/tb_mirror_pixel_memory_array.sv ====
// testbench for the mirror pixel array
`timescale 1ns/1ps
module tb_mirror_pixel_memory_array;
  localparam int COLS = 32;
  localparam int ROWS = 32;
  localparam int GROUPS = 2;
  // only columns 14..17 lie outside the border band
  localparam logic [COLS-1:0] ON_MASK = 32'h0003C000;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              link_clk;
  logic [15:0]       link_data;
  logic              link_row_start;
  logic [GROUPS-1:0] reset_request = 2'h0;
  logic              link_ready;
  logic [GROUPS-1:0] mrgs;
  logic [COLS-1:0]   ctrue;
  logic [COLS-1:0]   ccomp;
  logic [COLS-1:0]   tilt;
  logic [4:0]        view_row = 5'h00;
  logic              reset_busy;
  int                fail_count = 0;
  int                samples_checked = 0;
  always #2 clk = ~clk;
  mpa_link_model PRT (.link_clk(link_clk), .link_data(link_data), .link_row_start(link_row_start));
  mpa_array #(.COLS(COLS), .ROWS(ROWS), .GROUPS(GROUPS), .LANES(16)) DUT (
    .clk(clk), .rst(rst), .link_clk(link_clk), .link_data(link_data),
    .link_row_start(link_row_start), .reset_request(reset_request), .link_ready(link_ready),
    .mirror_reset_group_signal(mrgs), .cell_true_row(ctrue), .cell_complement_output(ccomp),
    .mirror_tilt_row(tilt), .view_row(view_row), .reset_busy(reset_busy));
  task automatic test_done();
    $display("checked %0d bad %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check_row(input logic [COLS-1:0] got, input logic [COLS-1:0] exp,
                           input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic show(input logic [4:0] r);
    @(posedge clk);
    #1 view_row = r;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // rows are loaded whole before any pulse is asked
  task automatic load(input logic [15:0] value);
    PRT.send_rows(ROWS, COLS / 16, value);
    repeat (10) @(posedge clk);
  endtask
  // request stays up until busy answers, bounded wait either way
  task automatic fire(input logic [GROUPS-1:0] g);
    int i;
    @(posedge clk);
    #1 reset_request = g;
    for (i = 0; i < 20 && reset_busy !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    reset_request = 2'h0;
    if (i == 20) begin
      fail_count++;
      $display("BAD %0t reset request not taken", $time);
    end
    for (i = 0; i < 20 && reset_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 20) begin
      fail_count++;
      $display("BAD %0t reset sequence never ended", $time);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic t_all_off();
    load(16'h0000);
    fire(2'h3);
    show(5'd15);
    check_row(tilt, '0, "tilt after zeros");
    check_row(ctrue, '0, "true after zeros");
    check_row(ccomp, '1, "comp after zeros");
  endtask
  task automatic t_write_holds();
    load(16'hFFFF);
    show(5'd15);
    check_row(tilt, '0, "tilt moved on write");
    check_row(ctrue, '1, "true after ones");
    check_row(ccomp, '0, "comp after ones");
  endtask
  task automatic t_groups();
    fire(2'h1);
    show(5'd15);
    check_row(tilt, ON_MASK, "group0 on");
    show(5'd16);
    check_row(tilt, '0, "group1 moved");
    show(5'd2);
    check_row(tilt, '0, "border row on");
    fire(2'h2);
    show(5'd16);
    check_row(tilt, ON_MASK, "group1 on");
    show(5'd15);
    check_row(tilt, ON_MASK, "group0 lost");
  endtask
  initial begin
    #50000;
    fail_count++;
    test_done();
  end
  // the bench alone sequences every mode of the array
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_all_off();
    t_write_holds();
    t_groups();
    test_done();
  end
endmodule
bind mpa_array mpa_checker #(.COLS(COLS), .ROWS(ROWS), .GROUPS(GROUPS)) u_chk (
  .clk(clk), .rst(rst), .reset_request(reset_request), .link_ready(link_ready),
  .mirror_reset_group_signal(mirror_reset_group_signal), .cell_true_row(cell_true_row),
  .cell_complement_output(cell_complement_output), .mirror_tilt_row(mirror_tilt_row),
  .view_row(view_row), .reset_busy(reset_busy));
